/* File: ebr_pkg.sv */
// Shared constants and types for the external bus ready-read controller
`default_nettype none
package ebr_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [3:0] REG_TIMING = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hc;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing configuration value after reset: one cycle each, divider 1
  localparam logic [31:0] TIMING_RESET = 32'h0001_0111;

  // Least lead period and least half-period divider, in cycles
  localparam logic [3:0] MIN_LEAD = 4'h1;
  localparam logic [3:0] MIN_HALF_DIV = 4'h1;

  // Asynchronous ready sampling starts this many timing cycles early
  localparam logic [15:0] ASYNC_EARLY = 16'h0002;

  // Earliest elapsed count at which a ready sample can be taken
  localparam logic [15:0] FIRST_SAMPLE_MIN = 16'h0001;

  // Status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_WAITS_LSB = 8;

  // Zone timing configuration word as software sees it
  typedef struct packed {
    logic [11:0] unusedHi;            // [31:20] read as zero
    logic [3:0] halfDiv;              // [19:16] sys_clk per half timing cycle
    logic unusedMid;                  // [15] read as zero
    logic doubledTimingSelect;        // [14] bus clock at half timing rate
    logic readySyncSelect;            // [13] 0 synchronous, 1 asynchronous
    logic readySamplingEnable;        // [12] honour the ready input
    logic [3:0] readTrailCycles;      // [11:8]
    logic [3:0] readActiveCycles;     // [7:4]
    logic [3:0] readLeadCycles;       // [3:0]
  } ebr_timing_t;

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALIGN = 3'b001,
    ST_LEAD = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_TRAIL = 3'b100
  } ebr_state_t;

endpackage : ebr_pkg
`default_nettype wire

/* File: ebr_in_sync.sv */
// Three-stage input synchroniser with second/third stage agreement
`timescale 1ns/100ps
`default_nettype none
module ebr_in_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // Stage one is read only by stage two
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_syncOut;

  // Output moves only on bits where stages two and three agree
  always_comb begin
    next_syncOut = (stage2 & ~(stage2 ^ stage3))
                 | (syncOut & (stage2 ^ stage3));
  end

  // Synchronous reset to zero, then shift every clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= next_syncOut;
    end
  end

endmodule : ebr_in_sync
`default_nettype wire

/* File: ebr_read_ctrl.sv */
// External bus read sequencer with ready-extended wait states
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ebr_read_ctrl #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int AXI_AW = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External bus pins
  output logic busClockOutput,
  output logic zoneSelectN,
  output logic readStrobeN,
  output logic [ADDR_W-1:0] externalAddressBus,
  input wire logic [DATA_W-1:0] externalDataBus,
  input wire logic externalWaitReady
);

  // Raise a zero count to its least legal value
  function automatic logic [3:0] atLeast(input logic [3:0] v,
                                         input logic [3:0] lo);
    atLeast = (v < lo) ? lo : v;
  endfunction : atLeast

  // Configuration and bus-side state
  ebr_pkg::ebr_timing_t cfg;            // Zone timing configuration
  ebr_pkg::ebr_timing_t next_cfg;
  logic pending;                        // Read request waiting to start
  logic next_pending;
  logic [ADDR_W-1:0] pendAddr;          // Address of the waiting request
  logic [ADDR_W-1:0] next_pendAddr;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;

  // Timebase state
  logic [3:0] halfCnt;                  // sys_clk count inside a half
  logic [3:0] next_halfCnt;
  logic halfSel;                        // Second half of a timing cycle
  logic next_halfSel;
  logic timParity;                      // Odd timing cycle index
  logic next_timParity;
  logic next_busClk;
  logic timTick;                        // Last sys_clk of a timing cycle

  // Access sequencer state
  ebr_pkg::ebr_state_t state;
  ebr_pkg::ebr_state_t next_state;
  logic [15:0] elapsed;                 // Timing cycles since access start
  logic [15:0] next_elapsed;
  logic [15:0] waits;                   // Low ready samples so far
  logic [15:0] next_waits;
  logic readyFound;                     // Wait ended or ready unused
  logic next_readyFound;
  logic [DATA_W-1:0] rdData;            // Data captured at strobe release
  logic [DATA_W-1:0] next_rdData;
  logic done;                           // Last access completed
  logic next_done;
  logic [ADDR_W-1:0] next_addrOut;
  logic next_zoneN;
  logic next_readN;
  logic startTake;                      // Sequencer accepts the request

  // Synchronised pins
  logic readySync;
  logic [DATA_W-1:0] dataSync;

  // Ready pin through the three-stage synchroniser
  ebr_in_sync #(.WIDTH(1)) u_ready_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(externalWaitReady),
    .syncOut(readySync)
  );

  // Read data pins; the partner holds them stable until strobe release
  ebr_in_sync #(.WIDTH(DATA_W)) u_data_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(externalDataBus),
    .syncOut(dataSync)
  );

  // Derived access figures
  logic [3:0] leadEff;
  logic [3:0] halfDivEff;
  logic [15:0] nomEnd;
  logic [15:0] firstSample;
  logic busy;
  logic wrGo;
  logic rdGo;

  assign leadEff = atLeast(cfg.readLeadCycles, ebr_pkg::MIN_LEAD);
  assign halfDivEff = atLeast(cfg.halfDiv, ebr_pkg::MIN_HALF_DIV);
  assign nomEnd = {12'h000, leadEff} + {12'h000, cfg.readActiveCycles};
  // Async mode moves the first sample two cycles ahead of sync mode, to no earlier than count 1
  assign firstSample = !cfg.readySyncSelect ? nomEnd :
    (nomEnd > ebr_pkg::ASYNC_EARLY + ebr_pkg::FIRST_SAMPLE_MIN) ?
    nomEnd - ebr_pkg::ASYNC_EARLY : ebr_pkg::FIRST_SAMPLE_MIN;
  assign busy = pending || (state != ebr_pkg::ST_IDLE);

  // Timebase: timing cycle is two halves of halfDiv sys_clk each
  always_comb begin
    next_halfCnt = halfCnt + 4'h1;
    next_halfSel = halfSel;
    timTick = 1'b0;
    if (halfCnt >= halfDivEff - 4'h1) begin
      next_halfCnt = 4'h0;
      next_halfSel = ~halfSel;
      timTick = halfSel;
    end
    next_timParity = timTick ? ~timParity : timParity;
    // Half rate: high over even cycles, so even counts meet a rise
    if (cfg.doubledTimingSelect) begin
      next_busClk = ~next_timParity;
    end else begin
      next_busClk = ~next_halfSel;
    end
  end

  // Timebase registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      halfCnt <= 4'h0;
      halfSel <= 1'b0;
      timParity <= 1'b0;
      busClockOutput <= 1'b1;
    end else begin
      halfCnt <= next_halfCnt;
      halfSel <= next_halfSel;
      timParity <= next_timParity;
      busClockOutput <= next_busClk;
    end
  end

  // Sequencer: moves only at timing cycle boundaries
  always_comb begin
    logic [15:0] e1;
    logic [15:0] nw;
    logic nf;
    logic activeDone;
    e1 = elapsed + 16'h0001;
    nw = waits;
    nf = readyFound;
    activeDone = 1'b0;
    next_state = state;
    next_elapsed = elapsed;
    next_waits = waits;
    next_readyFound = readyFound;
    next_rdData = rdData;
    next_done = done;
    next_addrOut = externalAddressBus;
    startTake = 1'b0;
    if (timTick) begin
      case (state)
        ebr_pkg::ST_IDLE: begin
          if (pending) begin
            // Half rate and next cycle odd: one aligning cycle first
            if (cfg.doubledTimingSelect && !timParity) begin
              next_state = ebr_pkg::ST_ALIGN;
            end else begin
              next_state = ebr_pkg::ST_LEAD;
              startTake = 1'b1;
            end
          end
        end
        ebr_pkg::ST_ALIGN: begin
          // Controls stayed inactive; lead now meets a rising edge
          next_state = ebr_pkg::ST_LEAD;
          startTake = 1'b1;
        end
        ebr_pkg::ST_LEAD, ebr_pkg::ST_ACTIVE, ebr_pkg::ST_TRAIL: begin
          // Ready sample at this boundary, once the first point is due
          if (!nf && e1 >= firstSample) begin
            if (readySync) begin
              nf = 1'b1;
            end else begin
              nw = waits + 16'h0001;
            end
          end
          activeDone = nf && (e1 >= nomEnd + nw);
          next_elapsed = e1;
          next_waits = nw;
          next_readyFound = nf;
          // Capture read data as the strobe is released
          if (activeDone && state != ebr_pkg::ST_TRAIL) begin
            next_rdData = dataSync;
          end
          if (activeDone &&
              e1 >= nomEnd + nw + {12'h000, cfg.readTrailCycles}) begin
            next_state = ebr_pkg::ST_IDLE;
            next_done = 1'b1;
          end else if (activeDone) begin
            next_state = ebr_pkg::ST_TRAIL;
          end else if (e1 >= {12'h000, leadEff}) begin
            next_state = ebr_pkg::ST_ACTIVE;
          end
        end
        default: begin
          next_state = ebr_pkg::ST_IDLE;
        end
      endcase
      if (startTake) begin
        next_addrOut = pendAddr;
        next_elapsed = 16'h0000;
        next_waits = 16'h0000;
        // Sampling off: no sample ever taken, counts alone decide
        next_readyFound = !cfg.readySamplingEnable;
        next_done = 1'b0;
      end
    end
    // Strobes from the next state; alignment shows as inactive
    next_zoneN = !(next_state == ebr_pkg::ST_LEAD ||
                   next_state == ebr_pkg::ST_ACTIVE ||
                   next_state == ebr_pkg::ST_TRAIL);
    next_readN = !(next_state == ebr_pkg::ST_ACTIVE);
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= ebr_pkg::ST_IDLE;
      elapsed <= 16'h0000;
      waits <= 16'h0000;
      readyFound <= 1'b1;
      rdData <= '0;
      done <= 1'b0;
      externalAddressBus <= '0;
      zoneSelectN <= 1'b1;
      readStrobeN <= 1'b1;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
      waits <= next_waits;
      readyFound <= next_readyFound;
      rdData <= next_rdData;
      done <= next_done;
      externalAddressBus <= next_addrOut;
      zoneSelectN <= next_zoneN;
      readStrobeN <= next_readN;
    end
  end

  // AXI handshakes: write waits for both address and data
  assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rdGo = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wrGo;
  assign s_axi_wready = wrGo;
  assign s_axi_arready = !s_axi_rvalid;

  // Register file next values
  always_comb begin
    logic [31:0] cfgWord;
    cfgWord = cfg;
    next_cfg = cfg;
    next_pending = pending && !startTake;
    next_pendAddr = pendAddr;
    next_bresp = s_axi_bresp;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    if (wrGo) begin
      next_bvalid = 1'b1;
      next_bresp = ebr_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        ebr_pkg::REG_TIMING: begin
          for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb[b]) begin
              cfgWord[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
            end
          end
          next_cfg = cfgWord;
          // Unused fields always read back as zero
          next_cfg.unusedHi = 12'h000;
          next_cfg.unusedMid = 1'b0;
        end
        ebr_pkg::REG_ADDR: begin
          // Only one read in flight; a request while busy is refused
          if (busy) begin
            next_bresp = ebr_pkg::RESP_SLVERR;
          end else begin
            next_pending = 1'b1;
            next_pendAddr = s_axi_wdata[ADDR_W-1:0];
          end
        end
        default: begin
          next_bresp = ebr_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rdGo) begin
      next_rvalid = 1'b1;
      next_rresp = ebr_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        ebr_pkg::REG_TIMING: begin
          next_rdata = cfg;
        end
        ebr_pkg::REG_ADDR: begin
          next_rdata[ADDR_W-1:0] = externalAddressBus;
        end
        ebr_pkg::REG_STATUS: begin
          next_rdata[ebr_pkg::STAT_BUSY] = busy;
          next_rdata[ebr_pkg::STAT_DONE] = done;
          next_rdata[ebr_pkg::STAT_WAITS_LSB +: 8] = waits[7:0];
        end
        ebr_pkg::REG_RDATA: begin
          next_rdata[DATA_W-1:0] = rdData;
        end
        default: begin
          next_rresp = ebr_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Register file and response registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= ebr_pkg::TIMING_RESET;
      pending <= 1'b0;
      pendAddr <= '0;
      s_axi_bresp <= ebr_pkg::RESP_OKAY;
      s_axi_bvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ebr_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pending <= next_pending;
      pendAddr <= next_pendAddr;
      s_axi_bresp <= next_bresp;
      s_axi_bvalid <= next_bvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
    end
  end

endmodule : ebr_read_ctrl
`default_nettype wire

/* File: ebr_monitor.sv */
// Checker for the ready-read controller's external bus pins
`timescale 1ns/100ps
`default_nettype none
module ebr_monitor #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16,
  parameter int AXI_AW = 4
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic busClockOutput,
  input wire logic zoneSelectN,
  input wire logic readStrobeN,
  input wire logic [ADDR_W-1:0] externalAddressBus,
  input wire logic externalWaitReady
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  ebr_pkg::ebr_timing_t cfg, next_cfg; // Shadow of the timing word
  logic [15:0] lowCnt, next_lowCnt; // Strobe low time so far
  logic rdyDip, next_rdyDip; // Ready seen low in this access
  logic [15:0] unit, fixLow; // Timing cycle, plain active time
  logic leadOdd; // Lead of 0 runs as 1
  logic cfgHit; // Register write taken this edge
  assign unit = {11'h0, cfg.halfDiv == 4'h0 ? 4'h1 : cfg.halfDiv, 1'b0};
  assign fixLow = unit * {12'h0, cfg.readActiveCycles};
  assign leadOdd = cfg.readLeadCycles == 4'h0 || cfg.readLeadCycles[0];
  assign cfgHit = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  // Next helper values; full strobes assumed by the bench
  always_comb begin
    next_cfg = cfg;
    if (cfgHit && s_axi_awaddr == ebr_pkg::REG_TIMING) begin
      next_cfg = s_axi_wdata;
    end
    next_lowCnt = readStrobeN ? 16'h0 : lowCnt + 16'h1;
    next_rdyDip = !zoneSelectN && (rdyDip || !externalWaitReady);
  end
  // Helper registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= ebr_pkg::TIMING_RESET;
      lowCnt <= 16'h0;
      rdyDip <= 1'b0;
    end else begin
      cfg <= next_cfg;
      lowCnt <= next_lowCnt;
      rdyDip <= next_rdyDip;
    end
  end
  // Lead: zone active, strobe still idle
  sequence s_leadOpen;
    !zoneSelectN && readStrobeN;
  endsequence
  property p_leadOnRise;
    $fell(zoneSelectN) |-> $rose(busClockOutput);
  endproperty
  a_leadOnRise: assert property (p_leadOnRise)
    else $error("access began off a bus clock rise");
  property p_leadHeld;
    $fell(zoneSelectN) |-> s_leadOpen[*2];
  endproperty
  a_leadHeld: assert property (p_leadHeld)
    else $error("read strobe came before the lead ended");
  property p_quietOutside;
    zoneSelectN |-> readStrobeN;
  endproperty
  a_quietOutside: assert property (p_quietOutside)
    else $error("read strobe active outside an access");
  property p_addrHold;
    !$fell(zoneSelectN) |-> $stable(externalAddressBus);
  endproperty
  a_addrHold: assert property (p_addrHold)
    else $error("address moved outside an access start");
  property p_fixedActive;
    $rose(readStrobeN) && !cfg.readySamplingEnable |-> lowCnt == fixLow;
  endproperty
  a_fixedActive: assert property (p_fixedActive)
    else $error("strobe length differs from programmed active");
  property p_noWait;
    $rose(readStrobeN) && cfg.readySamplingEnable && !rdyDip
      |-> lowCnt == fixLow;
  endproperty
  a_noWait: assert property (p_noWait)
    else $error("wait added while ready stayed high");
  property p_waitWhole;
    $rose(readStrobeN) && cfg.readySamplingEnable
      |-> lowCnt >= fixLow && lowCnt % unit == 16'h0;
  endproperty
  a_waitWhole: assert property (p_waitWhole)
    else $error("wait time not whole timing cycles");
  property p_strobeParity;
    $fell(readStrobeN) && cfg.doubledTimingSelect
      |-> $changed(busClockOutput) && busClockOutput == !leadOdd;
  endproperty
  a_strobeParity: assert property (p_strobeParity)
    else $error("strobe on wrong bus clock edge");
  property p_zoneOnClock;
    $changed(zoneSelectN) |-> $changed(busClockOutput);
  endproperty
  a_zoneOnClock: assert property (p_zoneOnClock)
    else $error("zone select moved off a bus clock edge");
endmodule : ebr_monitor
bind ebr_read_ctrl ebr_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .AXI_AW(AXI_AW)) monitorInst (.sys_clk(sys_clk), .srst(srst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .busClockOutput(busClockOutput),
  .zoneSelectN(zoneSelectN), .readStrobeN(readStrobeN),
  .externalAddressBus(externalAddressBus),
  .externalWaitReady(externalWaitReady));
`default_nettype wire

/* File: ebr_mem_model.sv */
// Slow external memory answering reads with a stretchable ready
`timescale 1ns/100ps
`default_nettype none
module ebr_mem_model (
  input wire logic sys_clk,
  input wire logic zoneSelectN,
  input wire logic readStrobeN,
  input wire logic [18:0] externalAddressBus,
  input wire logic [7:0] holdCycles,
  output logic [15:0] externalDataBus,
  output logic externalWaitReady
);
  logic [7:0] lowCnt = 8'h0; // Strobe-low cycles this access
  logic [15:0] junk = 16'h5a5a; // Released bus: flips every cycle
  // Count strobe time; a released bus first shows the inverse of the last value
  always_ff @(posedge sys_clk) begin
    junk <= ~externalDataBus;
    if (zoneSelectN) begin
      lowCnt <= 8'h0;
    end else if (!readStrobeN && lowCnt != 8'hff) begin
      lowCnt <= lowCnt + 8'h1;
    end
  end
  // Ready low from select until data has had its time
  assign externalWaitReady = zoneSelectN || lowCnt >= holdCycles;
  // Data only while the read strobe is active
  assign externalDataBus = readStrobeN ? junk
    : externalAddressBus[15:0] ^ 16'ha5c3;
endmodule : ebr_mem_model
`default_nettype wire

/* File: ebr_read_ctrl_tb.sv */
// Self-checking bench for the external bus ready-read controller
`timescale 1ns/100ps
`default_nettype none
module ebr_read_ctrl_tb;
  logic sys_clk = 1'b0; // 50 MHz
  logic srst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic busClockOutput, zoneSelectN, readStrobeN, externalWaitReady;
  logic [18:0] externalAddressBus;
  logic [15:0] externalDataBus;
  logic [7:0] holdCycles = 8'h0; // Partner ready delay
  logic [15:0] stCnt = 16'h0, znCnt = 16'h0; // Low-time meters
  logic [15:0] lastLow = 16'h0, lastZone = 16'h0;
  int fails = 0, numChecks = 0, cycles = 0;
  always #10 sys_clk = ~sys_clk;
  ebr_read_ctrl DUT (.sys_clk(sys_clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .busClockOutput(busClockOutput),
    .zoneSelectN(zoneSelectN), .readStrobeN(readStrobeN),
    .externalAddressBus(externalAddressBus),
    .externalDataBus(externalDataBus),
    .externalWaitReady(externalWaitReady));
  ebr_mem_model partner (.sys_clk(sys_clk), .zoneSelectN(zoneSelectN),
    .readStrobeN(readStrobeN), .externalAddressBus(externalAddressBus),
    .holdCycles(holdCycles), .externalDataBus(externalDataBus),
    .externalWaitReady(externalWaitReady));
  // Verdict and end of run, reached from the watchdog and the main sequence
  task automatic summarize;
    if (fails == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Meter strobe and zone low times; watchdog against hangs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    stCnt <= readStrobeN ? 16'h0 : stCnt + 16'h1;
    if (readStrobeN && stCnt != 16'h0) lastLow <= stCnt;
    znCnt <= zoneSelectN ? 16'h0 : znCnt + 16'h1;
    if (zoneSelectN && znCnt != 16'h0) lastZone <= znCnt;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  // Compare and report
  task automatic chk(input string n, input logic [31:0] e, g);
    numChecks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask : chk
  // Write: address and data together, bready held until bvalid
  // Design outputs are looked at mid-cycle, where they have settled
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic awTaken;
    logic wTaken;
    logic bSeen;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      awTaken = s_axi_awvalid && s_axi_awready;
      wTaken = s_axi_wvalid && s_axi_wready;
      bSeen = (s_axi_bvalid === 1'b1);
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (awTaken) s_axi_awvalid <= 1'b0;
      if (wTaken) s_axi_wvalid <= 1'b0;
    end while (!bSeen);
    s_axi_bready <= 1'b0;
  endtask : axiWrite
  // Read: rready held until rvalid
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic arTaken;
    logic rSeen;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      arTaken = s_axi_arvalid && s_axi_arready;
      rSeen = (s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (arTaken) s_axi_arvalid <= 1'b0;
    end while (!rSeen);
    s_axi_rready <= 1'b0;
  endtask : axiRead
  // One external read, half-period 4, so a timing cycle is 8 clocks
  task automatic runAcc(input logic [3:0] l, a, t, input logic u, y, dbl,
      input logic [7:0] h, w, input logic [18:0] ad);
    logic [31:0] v;
    logic [1:0] r;
    holdCycles <= h;
    axiWrite(ebr_pkg::REG_TIMING, {16'h4, 1'b0, dbl, y, u, t, a, l}, r);
    axiWrite(ebr_pkg::REG_ADDR, {13'h0, ad}, r);
    while (zoneSelectN) @(posedge sys_clk);
    axiWrite(ebr_pkg::REG_ADDR, 32'h0, r);
    chk("busyResp", {30'h0, ebr_pkg::RESP_SLVERR}, {30'h0, r});
    while (!zoneSelectN) @(posedge sys_clk);
    axiRead(ebr_pkg::REG_STATUS, v, r);
    chk("status", {16'h0, w, 8'h2}, v & 32'hff03);
    chk("strobeLow", 32'h8 * (a + w), {16'h0, lastLow});
    chk("zoneLow", 32'h8 * (l + a + w + t), {16'h0, lastZone});
    axiRead(ebr_pkg::REG_RDATA, v, r);
    chk("readData", {16'h0, ad[15:0] ^ 16'ha5c3}, v);
    chk("addrHold", {13'h0, ad}, {13'h0, externalAddressBus});
  endtask : runAcc
  // Main sequence
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    chk("addrReset", 32'h0, {13'h0, externalAddressBus});
    axiRead(ebr_pkg::REG_TIMING, v, r);
    chk("timingReset", ebr_pkg::TIMING_RESET, v);
    axiWrite(ebr_pkg::REG_STATUS, 32'h0, r);
    chk("readOnlyResp", {30'h0, ebr_pkg::RESP_SLVERR}, {30'h0, r});
    runAcc(4'h1, 4'h3, 4'h1, 1, 0, 0, 8'h0, 8'h0, 19'h12345);
    runAcc(4'h1, 4'h3, 4'h1, 1, 0, 0, 8'h22, 8'h2, 19'h7abcd);
    runAcc(4'h1, 4'h3, 4'h2, 1, 1, 0, 8'h0, 8'h0, 19'h00f0f);
    runAcc(4'h2, 4'h3, 4'h1, 1, 1, 0, 8'h1a, 8'h3, 19'h5a5a5);
    runAcc(4'h1, 4'h2, 4'h2, 0, 0, 0, 8'h3c, 8'h0, 19'h3c3c3);
    runAcc(4'h1, 4'h2, 4'h1, 0, 0, 1, 8'h0, 8'h0, 19'h01234);
    runAcc(4'h2, 4'h1, 4'h2, 0, 0, 1, 8'h0, 8'h0, 19'h6edcb);
    runAcc(4'h1, 4'h1, 4'h1, 0, 0, 1, 8'h0, 8'h0, 19'h40001);
    srst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    axiRead(ebr_pkg::REG_TIMING, v, r);
    chk("timingReset2", ebr_pkg::TIMING_RESET, v);
    summarize();
  end
endmodule : ebr_read_ctrl_tb
`default_nettype wire
